// ---- rtl/sail_top.sv ----
`default_nettype none
// How it works
// - Two select pins choose the serial format.
// - Word width pin selects 16 or 18 bits.
// - MSB first, left word before right.
// - Bit clock only shifts data; bursts allowed.
// - Right-justified: delay 14 or 16 bits.
// - I2S: left low, one bit delay.
// - Left-justified: left high, no delay.
// - DSP mode: frame pulse, falling-edge sampling.
// - Packed 16-bit mode at 32 bit clocks.
// - Control byte bit 7 picks channel register.
// - Bit 6 silences the channel.
// - Bits 5-0 attenuation in 1 dB steps.
// - Both registers reset to unsilenced, zero attenuation.
// - New level applies at next frame edge.
// - External silence pin overrides registers.
// - Emphasis enable drives both switch outputs.
// - Rate loop runs fast, then locks and goes slow together.
// - Power-down release zeroes path, restores defaults.
module sail_top (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	input wire logic powerdown_reset_pin_n_i,
	input wire logic port_format_sel_lo_i,
	input wire logic port_format_sel_hi_i,
	input wire logic word_width_18_i,
	input wire logic emphasis_filter_enable_i,
	input wire logic silence_pin_i,
	input wire logic bit_clk_i,
	input wire logic frame_clk_i,
	input wire logic serial_data_i,
	input wire logic control_shift_clock_i,
	input wire logic control_serial_in_i,
	input wire logic control_load_strobe_i,
	input wire logic sample_ready_i,
	output logic sample_valid_o,
	output logic [17:0] left_sample_o,
	output logic [17:0] right_sample_o,
	output logic left_silence_o,
	output logic right_silence_o,
	output logic [5:0] left_level_reduction_code_o,
	output logic [5:0] right_level_reduction_code_o,
	output logic left_emphasis_switch_o,
	output logic right_emphasis_switch_o,
	output logic rate_locked_o,
	output logic rate_slow_mode_o
);
	logic [1:0] s_bclk_q;
	logic [1:0] s_fclk_q;
	logic [1:0] s_sd_q;
	logic [1:0] s_control_shift_clock_q;
	logic [1:0] s_cdat_q;
	logic [1:0] s_cld_q;
	logic [1:0] s_pdn_q;
	logic [1:0] s_fs0_q;
	logic [1:0] s_fs1_q;
	logic [1:0] s_w18_q;
	logic [1:0] s_emp_q;
	logic [1:0] s_mute_q;
	logic bclk_d1_q;
	logic fclk_d1_q;
	logic control_shift_clock_d1_q;
	logic cld_d1_q;
	logic pdn_d1_q;
	logic srst;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_bclk_q <= 2'h0;
			s_fclk_q <= 2'h0;
			s_sd_q <= 2'h0;
			s_control_shift_clock_q <= 2'h0;
			s_cdat_q <= 2'h0;
			s_cld_q <= 2'h0;
			s_pdn_q <= 2'h0;
			s_fs0_q <= 2'h0;
			s_fs1_q <= 2'h0;
			s_w18_q <= 2'h0;
			s_emp_q <= 2'h0;
			s_mute_q <= 2'h0;
		end else if (clk_en_i) begin
			s_bclk_q <= {s_bclk_q[0], bit_clk_i};
			s_fclk_q <= {s_fclk_q[0], frame_clk_i};
			s_sd_q <= {s_sd_q[0], serial_data_i};
			s_control_shift_clock_q <= {s_control_shift_clock_q[0], control_shift_clock_i};
			s_cdat_q <= {s_cdat_q[0], control_serial_in_i};
			s_cld_q <= {s_cld_q[0], control_load_strobe_i};
			s_pdn_q <= {s_pdn_q[0], powerdown_reset_pin_n_i};
			s_fs0_q <= {s_fs0_q[0], port_format_sel_lo_i};
			s_fs1_q <= {s_fs1_q[0], port_format_sel_hi_i};
			s_w18_q <= {s_w18_q[0], word_width_18_i};
			s_emp_q <= {s_emp_q[0], emphasis_filter_enable_i};
			s_mute_q <= {s_mute_q[0], silence_pin_i};
		end
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bclk_d1_q <= 1'b0;
			fclk_d1_q <= 1'b0;
			control_shift_clock_d1_q <= 1'b0;
			cld_d1_q <= 1'b0;
			pdn_d1_q <= 1'b0;
		end else if (clk_en_i) begin
			bclk_d1_q <= s_bclk_q[1];
			fclk_d1_q <= s_fclk_q[1];
			control_shift_clock_d1_q <= s_control_shift_clock_q[1];
			cld_d1_q <= s_cld_q[1];
			pdn_d1_q <= s_pdn_q[1];
		end
	end
	logic bclk_rise;
	logic bclk_fall;
	logic fclk_edge;
	logic fclk_rise;
	logic control_shift_clock_rise;
	logic cld_rise;
	sail_pkg::sail_fmt_t fmt;
	logic w18;
	assign bclk_rise = s_bclk_q[1] && !bclk_d1_q;
	assign bclk_fall = !s_bclk_q[1] && bclk_d1_q;
	assign fclk_edge = s_fclk_q[1] != fclk_d1_q;
	assign fclk_rise = s_fclk_q[1] && !fclk_d1_q;
	assign control_shift_clock_rise = s_control_shift_clock_q[1] && !control_shift_clock_d1_q;
	assign cld_rise = s_cld_q[1] && !cld_d1_q;
	// Held in reset while the pin is low; released state is all defaults except left_sample_o and right_sample_o, which keep their last words.
	assign srst = !s_pdn_q[1] || !pdn_d1_q;
	assign fmt = sail_sail_fmt(s_fs1_q[1], s_fs0_q[1]);
	assign w18 = s_w18_q[1];
	function automatic sail_pkg::sail_fmt_t sail_sail_fmt(input logic hi, input logic lo);
		sail_sail_fmt = sail_pkg::sail_fmt_t'({hi, lo});
	endfunction

	// Serial audio receiver.
	logic [5:0] bitcnt_q;
	logic [5:0] got_q;
	logic [17:0] sh_q;
	logic side_q;
	logic [17:0] left_hold_q;
	logic [17:0] right_hold_q;
	logic push_q;
	logic pair_q;
	logic pk_q;
	logic [5:0] dly;
	logic [5:0] wlen;
	logic samp;
	logic cur_left;
	logic frame_start;
	logic buf_ready;
	assign wlen = w18 ? 6'(sail_pkg::SAIL_W18) : 6'(sail_pkg::SAIL_W16);
	always_comb begin
		case (fmt)
			sail_pkg::SAIL_FMT_RJ: dly = w18 ? sail_pkg::SAIL_RJ_DLY18 : sail_pkg::SAIL_RJ_DLY16;
			sail_pkg::SAIL_FMT_I2S: dly = sail_pkg::SAIL_I2S_DLY;
			default: dly = 6'h00;
		endcase
	end
	// Sampling edge per format.
	assign samp = (fmt == sail_pkg::SAIL_FMT_DSP) ? bclk_fall && !s_fclk_q[1] : bclk_rise;
	// Channel chosen by frame level, or by pulse order in DSP mode.
	always_comb begin
		case (fmt)
			sail_pkg::SAIL_FMT_I2S: cur_left = !s_fclk_q[1];
			sail_pkg::SAIL_FMT_DSP: cur_left = side_q;
			default: cur_left = s_fclk_q[1];
		endcase
	end
	assign frame_start = (fmt == sail_pkg::SAIL_FMT_DSP) ? fclk_rise : fclk_edge;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bitcnt_q <= 6'h00;
			got_q <= 6'h00;
			sh_q <= 18'h00000;
			side_q <= 1'b0;
			left_hold_q <= 18'h00000;
			right_hold_q <= 18'h00000;
			push_q <= 1'b0;
			pair_q <= 1'b0;
			pk_q <= 1'b0;
		end else if (clk_en_i) begin
			push_q <= 1'b0;
			if (srst) begin
				bitcnt_q <= 6'h00;
				got_q <= 6'h00;
				sh_q <= 18'h00000;
				side_q <= 1'b0;
				left_hold_q <= 18'h00000;
				right_hold_q <= 18'h00000;
				pair_q <= 1'b0;
				pk_q <= 1'b0;
			end else if (frame_start) begin
				bitcnt_q <= 6'h00;
				pk_q <= bitcnt_q == sail_pkg::SAIL_PACKED_BITS;
				got_q <= 6'h00;
				if (fmt == sail_pkg::SAIL_FMT_DSP) begin
					side_q <= !pair_q;
				end
			end else if (samp) begin
				if (bitcnt_q != 6'h3f) begin
					bitcnt_q <= bitcnt_q + 6'h01;
				end
				// A half of exactly 16 bit clocks marks packed words that start at the frame edge.
				if ((bitcnt_q >= dly || (fmt == sail_pkg::SAIL_FMT_RJ && !w18 && pk_q)) && got_q < wlen) begin
					sh_q <= {sh_q[16:0], s_sd_q[1]};
					got_q <= got_q + 6'h01;
					if (got_q == wlen - 6'h01) begin
						if (cur_left) begin
							left_hold_q <= w18 ? {sh_q[16:0], s_sd_q[1]} : {sh_q[14:0], s_sd_q[1], 2'b00};
							pair_q <= 1'b1;
							if (fmt == sail_pkg::SAIL_FMT_DSP) begin
								side_q <= 1'b0;
							end
						end else if (pair_q) begin
							right_hold_q <= w18 ? {sh_q[16:0], s_sd_q[1]} : {sh_q[14:0], s_sd_q[1], 2'b00};
							push_q <= 1'b1;
							pair_q <= 1'b0;
						end
					end
				end
			end
		end
	end
	logic bv;
	logic [36:0] bd;
	sail_buf2 u_buf (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.en_i(clk_en_i),
		.in_valid_i(push_q),
		.in_ready_o(buf_ready),
		.in_data_i({1'b0, left_hold_q, right_hold_q}),
		.out_valid_o(bv),
		.out_ready_i(srst || !sample_valid_o || sample_ready_i),
		.out_data_o(bd)
	);
	// Output register stage.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sample_valid_o <= 1'b0;
			left_sample_o <= 18'h00000;
			right_sample_o <= 18'h00000;
		end else if (clk_en_i) begin
			if (srst) begin
				sample_valid_o <= 1'b0;
			end else if (!sample_valid_o || sample_ready_i) begin
				sample_valid_o <= bv;
				if (bv) begin
					left_sample_o <= bd[35:18];
					right_sample_o <= bd[17:0];
				end
			end
		end
	end

	// Control port: shift, load, then apply on next frame edge.
	logic [7:0] cshift_q;
	logic [7:0] left_ctl_q;
	logic [7:0] right_ctl_q;
	logic left_pend_q;
	logic right_pend_q;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cshift_q <= 8'h00;
			left_ctl_q <= sail_pkg::SAIL_CTL_RESET;
			right_ctl_q <= sail_pkg::SAIL_CTL_RESET;
			left_pend_q <= 1'b0;
			right_pend_q <= 1'b0;
		end else if (clk_en_i) begin
			if (srst) begin
				cshift_q <= 8'h00;
				left_ctl_q <= sail_pkg::SAIL_CTL_RESET;
				right_ctl_q <= sail_pkg::SAIL_CTL_RESET;
				left_pend_q <= 1'b0;
				right_pend_q <= 1'b0;
			end else begin
				if (control_shift_clock_rise) begin
					cshift_q <= {cshift_q[6:0], s_cdat_q[1]};
				end
				if (cld_rise) begin
					if (cshift_q[sail_pkg::SAIL_CTL_SIDE_BIT]) begin
						right_ctl_q <= cshift_q;
						right_pend_q <= 1'b1;
					end else begin
						left_ctl_q <= cshift_q;
						left_pend_q <= 1'b1;
					end
				end
				// A load coinciding with a frame edge waits one more edge; never torn.
				if (fclk_edge && !cld_rise) begin
					left_pend_q <= 1'b0;
					right_pend_q <= 1'b0;
				end
			end
		end
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			left_silence_o <= 1'b0;
			right_silence_o <= 1'b0;
			left_level_reduction_code_o <= 6'h00;
			right_level_reduction_code_o <= 6'h00;
			left_emphasis_switch_o <= 1'b0;
			right_emphasis_switch_o <= 1'b0;
		end else if (clk_en_i) begin
			left_emphasis_switch_o <= s_emp_q[1] && !srst;
			right_emphasis_switch_o <= s_emp_q[1] && !srst;
			left_silence_o <= s_mute_q[1] || srst || left_ctl_q[sail_pkg::SAIL_CTL_SILENCE_BIT] && !left_pend_q;
			right_silence_o <= s_mute_q[1] || srst || right_ctl_q[sail_pkg::SAIL_CTL_SILENCE_BIT] && !right_pend_q;
			if (srst) begin
				left_level_reduction_code_o <= 6'h00;
				right_level_reduction_code_o <= 6'h00;
			end else if (fclk_edge && !cld_rise) begin
				left_level_reduction_code_o <= left_ctl_q[5:0];
				right_level_reduction_code_o <= right_ctl_q[5:0];
			end
		end
	end

	// Rate tracker: counts frame periods, fast until stable, then slow.
	logic [19:0] per_cnt_q;
	logic [19:0] per_q;
	logic [2:0] stable_q;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			per_cnt_q <= 20'h00000;
			per_q <= 20'h00000;
			stable_q <= 3'h0;
			rate_locked_o <= 1'b0;
			rate_slow_mode_o <= 1'b0;
		end else if (clk_en_i) begin
			if (srst) begin
				per_cnt_q <= 20'h00000;
				per_q <= 20'h00000;
				stable_q <= 3'h0;
				rate_locked_o <= 1'b0;
				rate_slow_mode_o <= 1'b0;
			end else if (fclk_rise) begin
				per_cnt_q <= 20'h00001;
				if (per_cnt_q > per_q + 20'(sail_pkg::SAIL_PERIOD_TOL) ||
					per_cnt_q + 20'(sail_pkg::SAIL_PERIOD_TOL) < per_q) begin
					per_q <= per_cnt_q;
					stable_q <= 3'h0;
					rate_slow_mode_o <= 1'b0;
					rate_locked_o <= 1'b0;
				end else begin
					per_q <= per_q - (per_q >> 4) + (per_cnt_q >> 4);
					if (stable_q != 3'(sail_pkg::SAIL_LOCK_FRAMES)) begin
						stable_q <= stable_q + 3'h1;
					end else begin
						rate_slow_mode_o <= 1'b1;
						rate_locked_o <= 1'b1;
					end
				end
			end else if (per_cnt_q != 20'hfffff) begin
				per_cnt_q <= per_cnt_q + 20'h00001;
			end
		end
	end
endmodule
`default_nettype wire

// ---- rtl/sail_pkg.sv ----
`default_nettype none
package sail_pkg;
	typedef enum logic [1:0] {
		SAIL_FMT_RJ = 2'b00,
		SAIL_FMT_I2S = 2'b01,
		SAIL_FMT_LJ = 2'b10,
		SAIL_FMT_DSP = 2'b11
	} sail_fmt_t;
	localparam int SAIL_W18 = 18;
	localparam int SAIL_W16 = 16;
	localparam logic [5:0] SAIL_RJ_DLY18 = 6'h0e;
	localparam logic [5:0] SAIL_RJ_DLY16 = 6'h10;
	localparam logic [5:0] SAIL_I2S_DLY = 6'h01;
	localparam logic [5:0] SAIL_PACKED_BITS = 6'h10;
	localparam int SAIL_CTL_SIDE_BIT = 7;
	localparam int SAIL_CTL_SILENCE_BIT = 6;
	localparam logic [7:0] SAIL_CTL_RESET = 8'h00;
	localparam int SAIL_CLK_MHZ = 200;
	localparam int SAIL_LOCK_MIN_MS = 100;
	localparam int SAIL_LOCK_MAX_MS = 200;
	localparam int SAIL_SLOW_BW_HZ = 15;
	localparam int SAIL_LOCK_FRAMES = 4;
	localparam int SAIL_PERIOD_TOL = 8;
endpackage
`default_nettype wire

// ---- rtl/sail_buf2.sv ----
`default_nettype none
// Two-entry buffer; a stalled reader loses no stored word, but words offered while it is full are refused.
module sail_buf2 (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [36:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [36:0] out_data_o
);
	logic [36:0] mem_q [2];
	logic wp_q;
	logic rp_q;
	logic [1:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready_o = cnt_q != 2'h2;
	assign out_valid_o = cnt_q != 2'h0;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_q[rp_q];
	always_ff @(posedge core_clk_i) begin
		if (en_i && push) begin
			mem_q[wp_q] <= in_data_i;
		end
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end else if (en_i) begin
			if (push) begin
				wp_q <= ~wp_q;
			end
			if (pop) begin
				rp_q <= ~rp_q;
			end
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

// ---- dv/sail_link_model.sv ----
`default_nettype none
// Audio sender: the bit clock runs only inside frames, idle slots carry the inverse of the last bit.
module sail_link_model;
	timeunit 1ns;
	timeprecision 100ps;
	logic bit_clk = 1'b0;
	logic frame_clk = 1'b0;
	logic data = 1'b0;
	task automatic send(input logic [1:0] fmt, input logic w18, input logic pk, input logic [17:0] l,
		input logic [17:0] r);
		int n;
		int st;
		int b;
		logic lft;
		n = pk ? 16 : 32;
		st = (fmt == 2'b00 && !pk) ? (w18 ? 14 : 16) : (fmt[0] ? 1 : 0);
		lft = (fmt != 2'b01);
		frame_clk = (fmt == 2'b11) ? 1'b0 : ~lft;
		#100;
		for (int k = 0; k < 2 * n; k++) begin
			b = (k % n) - st;
			#20;
			frame_clk = (fmt == 2'b11) ? (k % n == 0) : ((k < n) ? lft : ~lft);
			data = (b >= 0 && b < (w18 ? 18 : 16)) ? ((k < n) ? l[17 - b] : r[17 - b]) : ~data;
			#20 bit_clk = 1'b1;
			#40 bit_clk = 1'b0;
		end
		#20;
		frame_clk = (fmt == 2'b11) ? 1'b0 : lft;
	endtask
endmodule
`default_nettype wire

// ---- dv/sail_top_checker.sv ----
`default_nettype none
module sail_top_checker (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic powerdown_reset_pin_n_i,
	input wire logic emphasis_filter_enable_i,
	input wire logic silence_pin_i,
	input wire logic frame_clk_i,
	input wire logic sample_ready_i,
	input wire logic sample_valid_o,
	input wire logic [17:0] left_sample_o,
	input wire logic left_silence_o,
	input wire logic right_silence_o,
	input wire logic [5:0] left_level_reduction_code_o,
	input wire logic [5:0] right_level_reduction_code_o,
	input wire logic left_emphasis_switch_o,
	input wire logic right_emphasis_switch_o
);
	logic frm_q;
	logic [3:0] since_edge_q;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	// Counts cycles since the last frame edge or power-down, saturating.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frm_q <= 1'b0;
			since_edge_q <= 4'hf;
		end else begin
			frm_q <= frame_clk_i;
			if (frm_q != frame_clk_i || !powerdown_reset_pin_n_i) begin
				since_edge_q <= 4'h0;
			end else if (since_edge_q != 4'hf) begin
				since_edge_q <= since_edge_q + 4'h1;
			end
		end
	end
	sequence s_pd_held;
		!powerdown_reset_pin_n_i [*6];
	endsequence
	sequence s_offer_waits;
		sample_valid_o && !sample_ready_i && powerdown_reset_pin_n_i;
	endsequence
	a_offer_stands: assert property (s_offer_waits |=> sample_valid_o && $stable(left_sample_o))
		else $error("Sample offer changed before it was taken.");
	a_left_code_edge: assert property ($changed(left_level_reduction_code_o) |-> since_edge_q < 4'ha)
		else $error("Left level changed away from a frame edge.");
	a_right_code_edge: assert property ($changed(right_level_reduction_code_o) |-> since_edge_q < 4'ha)
		else $error("Right level changed away from a frame edge.");
	a_emph_on: assert property (emphasis_filter_enable_i [*6] |-> left_emphasis_switch_o && right_emphasis_switch_o)
		else $error("Emphasis switches not driven.");
	a_emph_off: assert property (!emphasis_filter_enable_i [*6] |-> !left_emphasis_switch_o && !right_emphasis_switch_o)
		else $error("Emphasis switches driven while disabled.");
	a_silence_pin: assert property (silence_pin_i [*6] |-> left_silence_o && right_silence_o)
		else $error("Silence pin did not silence both channels.");
	a_pd_silenced: assert property (s_pd_held |-> left_silence_o && right_silence_o)
		else $error("Channels not silenced in power-down.");
	a_pd_codes_cleared: assert property (s_pd_held |-> {left_level_reduction_code_o, right_level_reduction_code_o} == 12'h000)
		else $error("Level codes not cleared in power-down.");
endmodule
bind sail_top sail_top_checker u_sail_chk (.core_clk_i, .rst_i, .powerdown_reset_pin_n_i, .emphasis_filter_enable_i,
	.silence_pin_i, .frame_clk_i, .sample_ready_i, .sample_valid_o, .left_sample_o, .left_silence_o, .right_silence_o,
	.left_level_reduction_code_o, .right_level_reduction_code_o, .left_emphasis_switch_o, .right_emphasis_switch_o);
`default_nettype wire

// ---- dv/testbench.sv ----
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic powerdown_reset_pin_n_i = 1'b1;
	logic [1:0] fmt = 2'b01;
	logic word_width_18_i = 1'b1;
	logic emphasis_filter_enable_i = 1'b0;
	logic silence_pin_i = 1'b0;
	logic control_shift_clock_i = 1'b0;
	logic control_serial_in_i = 1'b0;
	logic control_load_strobe_i = 1'b0;
	logic sample_ready_i = 1'b0;
	logic sample_valid_o, left_silence_o, right_silence_o, left_emphasis_switch_o, right_emphasis_switch_o;
	logic [17:0] left_sample_o, right_sample_o;
	logic rate_locked_o, rate_slow_mode_o;
	logic [5:0] left_level_reduction_code_o, right_level_reduction_code_o;
	int fails = 0;
	int check_count = 0;
	sail_link_model link();
	sail_top DUT (.core_clk_i, .rst_i, .clk_en_i(1'b1), .powerdown_reset_pin_n_i, .port_format_sel_lo_i(fmt[0]),
		.port_format_sel_hi_i(fmt[1]), .word_width_18_i, .emphasis_filter_enable_i, .silence_pin_i,
		.bit_clk_i(link.bit_clk), .frame_clk_i(link.frame_clk), .serial_data_i(link.data), .control_shift_clock_i,
		.control_serial_in_i, .control_load_strobe_i, .sample_ready_i, .sample_valid_o, .left_sample_o,
		.right_sample_o, .left_silence_o, .right_silence_o, .left_level_reduction_code_o,
		.right_level_reduction_code_o, .left_emphasis_switch_o, .right_emphasis_switch_o, .rate_locked_o,
		.rate_slow_mode_o);
	always #2.5 core_clk_i = ~core_clk_i;
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic compare_value(input logic [17:0] got, input logic [17:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic ctl(input logic [11:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			control_serial_in_i = v[i];
			#20 control_shift_clock_i = 1'b1;
			#40 control_shift_clock_i = 1'b0;
			#20;
		end
		#20 control_load_strobe_i = 1'b1;
		#40 control_load_strobe_i = 1'b0;
		tick(2);
	endtask
	task automatic take(input logic [17:0] l, input logic [17:0] r);
		int t;
		t = 0;
		while (sample_valid_o !== 1'b1 && t < 3000) begin
			tick(1);
			t++;
		end
		if (t == 3000) begin
			fails++;
			final_report();
		end
		compare_value(left_sample_o, l);
		compare_value(right_sample_o, r);
		sample_ready_i = 1'b1;
		tick(1);
		sample_ready_i = 1'b0;
		tick(8);
	endtask
	function automatic logic [17:0] ex(input logic [17:0] v);
		return word_width_18_i ? v : {v[17:2], 2'b00};
	endfunction
	function automatic logic [17:0] lvl();
		return 18'({left_silence_o, right_silence_o, left_level_reduction_code_o, right_level_reduction_code_o});
	endfunction
	initial begin
		tick(2);
		rst_i = 1'b0;
		tick(4);
		compare_value(lvl(), 18'h00000);
		ctl(12'ha25, 12);
		ctl(12'h0c1, 8);
		compare_value(lvl(), 18'h00000);
		link.send(fmt, 1'b1, 1'b0, 18'h2a5c3, 18'h1f00f);
		take(18'h2a5c3, 18'h1f00f);
		compare_value(lvl(), 18'h01941);
		ctl(12'h07f, 8);
		ctl(12'h080, 8);
		for (int m = 0; m < 9; m++) begin
			fmt = (m == 8) ? 2'b10 : 2'(m >> 1);
			word_width_18_i = (m != 8) && m[0];
			tick(4);
			link.send(fmt, word_width_18_i, m == 8, 18'h2a5c3 ^ 18'(m), 18'h1d00e + 18'(m));
			take(ex(18'h2a5c3 ^ 18'(m)), ex(18'h1d00e + 18'(m)));
		end
		compare_value(lvl(), 18'h02fc0);
		fmt = 2'b00;
		tick(4);
		for (int k = 0; k < 7; k++) link.send(fmt, 1'b0, 1'b1, 18'h01110 << k, 18'h02220 << k);
		compare_value(18'({rate_locked_o, rate_slow_mode_o}), 18'h00003);
		take(18'h02220, 18'h04440);
		take(18'h04440, 18'h08880);
		take(18'h08880, 18'h11100);
		compare_value(18'(sample_valid_o), 18'h00000);
		silence_pin_i = 1'b1;
		tick(8);
		compare_value(18'({left_silence_o, right_silence_o}), 18'h00003);
		silence_pin_i = 1'b0;
		emphasis_filter_enable_i = 1'b1;
		tick(8);
		compare_value(18'({left_emphasis_switch_o, right_emphasis_switch_o}), 18'h00003);
		emphasis_filter_enable_i = 1'b0;
		tick(8);
		compare_value(18'({left_emphasis_switch_o, right_emphasis_switch_o}), 18'h00000);
		powerdown_reset_pin_n_i = 1'b0;
		tick(8);
		compare_value(18'({left_level_reduction_code_o, right_level_reduction_code_o}), 18'h00000);
		powerdown_reset_pin_n_i = 1'b1;
		silence_pin_i = 1'b1;
		tick(8);
		compare_value(lvl(), 18'h03000);
		silence_pin_i = 1'b0;
		tick(8);
		compare_value(lvl(), 18'h00000);
		final_report();
	end
endmodule
`default_nettype wire
